// ### design/bts_defines.vh
// bus transfer sequencer constants: register map, fields, delays
`ifndef BTS_DEFINES_VH
`define BTS_DEFINES_VH

// seconds tick: one second of clk at 250 MHz, sized to the prescaler
`define BTS_SEC_CYCLES      28'hEE6B280

// delays in seconds
`define BTS_T_LOSS_S        8'h05
`define BTS_T_BOTH_OPEN_S   8'h0A
`define BTS_T_GEN_CALL_S    8'h0F
`define BTS_T_STAB_S        8'h0A
`define BTS_T_TIE_S         8'h0A
`define BTS_T_GEN_RET_S     8'h05
`define BTS_T_GEN_TEST_S    8'h0A

// register byte offsets
`define BTS_REG_CTRL        12'h000
`define BTS_REG_CMD         12'h004
`define BTS_REG_STAT        12'h008
`define BTS_REG_GEN         12'h00C
`define BTS_REG_TANK        12'h010

// control register fields and reset value
`define BTS_CTRL_AUTO       0
`define BTS_CTRL_RETX       1
`define BTS_CTRL_TEST_LO    2
`define BTS_CTRL_TEST_HI    3
`define BTS_CTRL_GEN        4
`define BTS_CTRL_RST        5'h13

// command register fields (write one to act)
`define BTS_CMD_OPEN_TIE    0
`define BTS_CMD_CLOSE_MAIN  1
`define BTS_CMD_OPEN_GEN    3

// test selector codes
`define BTS_TEST_NONE       2'h0
`define BTS_TEST_BUS_A      2'h1
`define BTS_TEST_BUS_B      2'h2

`endif

// ### design/bts_sec_timer.v
// seconds timer: counts ticks while its condition holds, clears when it drops
`timescale 1ns/1ps
`default_nettype none
module bts_sec_timer
(
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // control
   input  wire       tick,
   input  wire       run,
   // elapsed seconds, saturating
   output reg  [7:0] cnt_q
);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_q <= 8'h00;
      else if (!run)
         cnt_q <= 8'h00;
      else if (tick && (cnt_q != 8'hFF))
         cnt_q <= cnt_q + 8'h01;
   end

endmodule // bts_sec_timer
`default_nettype wire

// ### design/bts_sequencer.v
// bus transfer sequencer: breaker and generator sequencing behind an apb slave
//
// Summary of operation
// - idle: both mains closed, tie open, mode automatic.
// - five seconds of loss on a bus opens its main.
// - tie closes after ten seconds, main open and bus dead.
// - tie never closes while both buses have lost source.
// - auto retransfer: ten seconds of normal voltage, then tie opens.
// - ten seconds after tie opens, main recloses if tie open, bus dead.
// - retransfer enable off holds retransfer; turning it on resumes.
// - manual mode: operator opens tie; main close only after stabilization.
// - test position simulates loss; five seconds later main opens.
// - tie never closes while both mains report closed.
// - test back to normal retransfers by the manual procedure.
// - ten seconds of loss on both buses opens both mains.
// - fifteen seconds of loss on both buses calls both generators.
// - each generator breaker closes once its set is running and available.
// - auto: ten seconds stable voltage, then generator breaker opens.
// - opening a generator breaker drops that generator's run request.
// - five seconds later main closes if generator breaker open, bus dead.
// - manual: operator opens generator breaker after stabilization expired.
// - bus A test: call generator, ten seconds, close its breaker; tie open.
// - bus B test: same for bus B breaker; bus A generator called too.
// - per generator discrete status inputs and an analog tank level.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bts_defines.vh"
module bts_sequencer
#(
   parameter [27:0] SEC_CYCLES = `BTS_SEC_CYCLES
)
(
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // source loss and no-voltage relays
   input  wire        src_loss_a,
   input  wire        src_loss_b,
   input  wire        dead_a,
   input  wire        dead_b,
   // breaker position contacts
   input  wire        main_a_open,
   input  wire        main_b_open,
   input  wire        tie_open,
   input  wire        gen_a_breaker_open,
   input  wire        gen_b_breaker_open,
   // generator a status
   input  wire        gen_a_fire,
   input  wire        gen_a_running,
   input  wire        gen_a_fault,
   input  wire        gen_a_leak,
   input  wire        gen_a_tank_hi,
   input  wire        gen_a_tank_lo,
   input  wire [15:0] gen_a_level,
   // generator b status
   input  wire        gen_b_fire,
   input  wire        gen_b_running,
   input  wire        gen_b_fault,
   input  wire        gen_b_leak,
   input  wire        gen_b_tank_hi,
   input  wire        gen_b_tank_lo,
   input  wire [15:0] gen_b_level,
   // breaker commands, high means close
   output wire        main_a_close,
   output wire        main_b_close,
   output reg         tie_close,
   output wire        gen_a_breaker_close,
   output wire        gen_b_breaker_close,
   // generator run requests
   output reg         gen_a_run,
   output reg         gen_b_run
);

   localparam [2:0] ST_NORM       = 3'h0;
   localparam [2:0] ST_TIE_WAIT   = 3'h1;
   localparam [2:0] ST_ON_TIE     = 3'h2;
   localparam [2:0] ST_TIE_OPENED = 3'h3;
   localparam [2:0] ST_GEN_WAIT   = 3'h4;
   localparam [2:0] ST_ON_GEN     = 3'h5;
   localparam [2:0] ST_GEN_OPENED = 3'h6;

   // one-hot bus flag for the test selector
   function [1:0] test_dec;
      input [1:0] sel;
      begin
         test_dec = {sel == `BTS_TEST_BUS_B, sel == `BTS_TEST_BUS_A};
      end
   endfunction

   reg  [27:0] pre_q;
   reg         tick_q;
   reg  [4:0]  ctrl_q;
   reg  [4:0]  cmd_q;
   reg  [31:0] rd_d;
   reg         hit_d;
   wire [7:0]  both_s;

   wire        auto_mode  = ctrl_q[`BTS_CTRL_AUTO];
   wire        retx_en    = ctrl_q[`BTS_CTRL_RETX];
   wire        gen_scheme = ctrl_q[`BTS_CTRL_GEN];
   wire [1:0]  test_hit   = test_dec(ctrl_q[`BTS_CTRL_TEST_HI:`BTS_CTRL_TEST_LO]);

   wire [1:0]  src_loss   = {src_loss_b, src_loss_a};
   wire [1:0]  dead       = {dead_b, dead_a};
   wire [1:0]  main_open  = {main_b_open, main_a_open};
   wire [1:0]  gbrk_open  = {gen_b_breaker_open, gen_a_breaker_open};
   wire [1:0]  gen_runs   = {gen_b_running, gen_a_running};
   wire [1:0]  gen_avail  = {~gen_b_fault & ~gen_b_fire, ~gen_a_fault & ~gen_a_fire};
   wire [5:0]  gen_a_stat = {gen_a_tank_lo, gen_a_tank_hi, gen_a_leak,
                             gen_a_fault, gen_a_running, gen_a_fire};
   wire [5:0]  gen_b_stat = {gen_b_tank_lo, gen_b_tank_hi, gen_b_leak,
                             gen_b_fault, gen_b_running, gen_b_fire};
   wire        both_loss  = src_loss_a & src_loss_b;
   wire        apb_setup  = psel & penable & ~pready;
   wire        apb_done   = psel & penable & pready;

   // seconds prescaler; a delay of n seconds waits for n+1 ticks, so never short
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pre_q  <= 28'h0000000;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (pre_q == SEC_CYCLES - 28'h0000001);
         if (pre_q == SEC_CYCLES - 28'h0000001)
            pre_q <= 28'h0000000;
         else
            pre_q <= pre_q + 28'h0000001;
      end
   end

   bts_sec_timer u_both
   (
      .clk   (clk),
      .rst   (rst),
      .tick  (tick_q),
      .run   (both_loss),
      .cnt_q (both_s)
   );

   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1)
      begin : bus
         reg  [2:0] st_q;
         reg  [2:0] st_d;
         reg        main_q;
         reg        gbrk_q;
         reg        run_q;
         reg        man_q;
         wire [7:0] loss_s;
         wire [7:0] stab_s;
         wire [7:0] seq_s;
         // a test position counts as a source loss on its bus
         wire       lost      = src_loss[b] | test_hit[b];
         wire       stab_done = stab_s > `BTS_T_STAB_S;
         wire       manual    = ~auto_mode | man_q;
         wire       seq_run   = (st_q == ST_TIE_WAIT) | (st_q == ST_TIE_OPENED) |
                                (st_q == ST_GEN_WAIT) | (st_q == ST_GEN_OPENED);
         wire       open_due  = (gen_scheme & both_loss) ?
                                (both_s > `BTS_T_BOTH_OPEN_S) :
                                (loss_s > `BTS_T_LOSS_S);

         bts_sec_timer u_loss
         (
            .clk   (clk),
            .rst   (rst),
            .tick  (tick_q),
            .run   (lost),
            .cnt_q (loss_s)
         );

         bts_sec_timer u_stab
         (
            .clk   (clk),
            .rst   (rst),
            .tick  (tick_q),
            .run   (~lost),
            .cnt_q (stab_s)
         );

         bts_sec_timer u_seq
         (
            .clk   (clk),
            .rst   (rst),
            .tick  (tick_q),
            .run   (seq_run),
            .cnt_q (seq_s)
         );

         always @*
         begin
            st_d = st_q;
            case (st_q)
               ST_NORM:
                  if (open_due)
                  begin
                     if (gen_scheme & (both_loss | test_hit[b]))
                        st_d = ST_GEN_WAIT;
                     else
                        st_d = ST_TIE_WAIT;
                  end
               ST_TIE_WAIT:
                  // source back before the tie closed: go straight to reclosing
                  if (stab_done)
                     st_d = ST_TIE_OPENED;
                  else if ((seq_s > `BTS_T_TIE_S) & main_open[b] & dead[b]
                           & ~both_loss
                           & (main_open[0] | main_open[1]))
                     st_d = ST_ON_TIE;
               ST_ON_TIE:
                  if (manual ? (cmd_q[`BTS_CMD_OPEN_TIE] & ~lost)
                             : (stab_done & retx_en))
                     st_d = ST_TIE_OPENED;
               ST_TIE_OPENED:
                  if (tie_open & dead[b] &
                      (manual ? (cmd_q[`BTS_CMD_CLOSE_MAIN + b] & stab_done)
                              : (seq_s > `BTS_T_TIE_S)))
                     st_d = ST_NORM;
               ST_GEN_WAIT:
                  if (run_q & gen_runs[b] & gen_avail[b]
                      & main_open[b] & dead[b]
                      & (~test_hit[b] | (seq_s > `BTS_T_GEN_TEST_S)))
                     st_d = ST_ON_GEN;
               ST_ON_GEN:
                  if (stab_done & (manual ? cmd_q[`BTS_CMD_OPEN_GEN + b]
                                          : retx_en))
                     st_d = ST_GEN_OPENED;
               ST_GEN_OPENED:
                  if (gbrk_open[b] & dead[b] & (seq_s > `BTS_T_GEN_RET_S)
                      & (~manual | cmd_q[`BTS_CMD_CLOSE_MAIN + b]))
                     st_d = ST_NORM;
               default:
                  st_d = ST_NORM;
            endcase
         end

         always @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               st_q   <= ST_NORM;
               main_q <= 1'b1;
               gbrk_q <= 1'b0;
               run_q  <= 1'b0;
               man_q  <= 1'b0;
            end
            else
            begin
               st_q   <= st_d;
               main_q <= (st_d == ST_NORM);
               gbrk_q <= (st_d == ST_ON_GEN);
               if ((st_d == ST_GEN_OPENED) | (st_d == ST_NORM))
                  run_q <= 1'b0;
               else if ((st_q == ST_GEN_WAIT) &
                        (test_hit[b] | (both_s > `BTS_T_GEN_CALL_S)))
                  run_q <= 1'b1;
               if (st_d == ST_NORM)
                  man_q <= 1'b0;
               else if ((st_q == ST_NORM) & test_hit[b])
                  man_q <= 1'b1;
            end
         end
      end
   endgenerate

   assign main_a_close        = bus[0].main_q;
   assign main_b_close        = bus[1].main_q;
   assign gen_a_breaker_close = bus[0].gbrk_q;
   assign gen_b_breaker_close = bus[1].gbrk_q;

   // shared tie and run outputs
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tie_close <= 1'b0;
         gen_a_run <= 1'b0;
         gen_b_run <= 1'b0;
      end
      else
      begin
         // gen scheme skips the tie states on a double loss or a test, so the tie stays open then
         tie_close <= (bus[0].st_d == ST_ON_TIE) | (bus[1].st_d == ST_ON_TIE);
         gen_a_run <= bus[0].run_q | (bus[1].run_q & test_hit[1]);
         gen_b_run <= bus[1].run_q;
      end
   end

   // read mux and address decode
   always @*
   begin
      rd_d  = 32'h00000000;
      hit_d = 1'b1;
      case (paddr)
         `BTS_REG_CTRL:
            rd_d = {27'h0000000, ctrl_q};
         `BTS_REG_CMD:
            rd_d = 32'h00000000;
         `BTS_REG_STAT:
            rd_d = {16'h0000, both_loss, gen_b_run, gen_a_run,
                    gen_b_breaker_close, gen_a_breaker_close, tie_close,
                    main_b_close, main_a_close,
                    1'b0, bus[1].st_q, 1'b0, bus[0].st_q};
         `BTS_REG_GEN:
            rd_d = {18'h00000, gen_b_stat, 2'h0, gen_a_stat};
         `BTS_REG_TANK:
            rd_d = {gen_b_level, gen_a_level};
         default:
            hit_d = 1'b0;
      endcase
   end

   // apb slave: one wait state, write lands on the completing edge
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q  <= `BTS_CTRL_RST;
         cmd_q   <= 5'h00;
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= apb_setup;
         cmd_q  <= 5'h00;
         if (apb_setup)
         begin
            prdata  <= pwrite ? 32'h00000000 : rd_d;
            pslverr <= ~hit_d;
         end
         else if (apb_done)
         begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
         end
         if (apb_done & pwrite)
         begin
            if (paddr == `BTS_REG_CTRL)
               ctrl_q <= pwdata[4:0];
            if (paddr == `BTS_REG_CMD)
               cmd_q <= pwdata[4:0];
         end
      end
   end

endmodule // bts_sequencer
`default_nettype wire

// ### verification/bts_field_model.sv
// field side model: breaker contacts, no-voltage relays and standby sets
`timescale 1ns/1ps
`default_nettype none
module bts_field_model
#(
   parameter int START = 12
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // commands from the sequencer
   input  wire logic main_a_close,
   input  wire logic main_b_close,
   input  wire logic tie_close,
   input  wire logic gen_a_breaker_close,
   input  wire logic gen_b_breaker_close,
   input  wire logic gen_a_run,
   input  wire logic gen_b_run,
   // contacts, relays and set status
   output wire logic main_a_open,
   output wire logic main_b_open,
   output wire logic tie_open,
   output wire logic gen_a_breaker_open,
   output wire logic gen_b_breaker_open,
   output wire logic dead_a,
   output wire logic dead_b,
   output wire logic gen_a_running,
   output wire logic gen_b_running
);
   logic [14:0] sh_q;
   int          ra_q;
   int          rb_q;
   // contacts trail the command by three cycles, like a slow mechanism
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sh_q <= 15'h0C63;
         ra_q <= 0;
         rb_q <= 0;
      end
      else
      begin
         sh_q <= {sh_q[9:0], gen_b_breaker_close, gen_a_breaker_close, tie_close,
                  main_b_close, main_a_close};
         ra_q <= !gen_a_run ? 0 : (ra_q < START ? ra_q + 1 : ra_q);
         rb_q <= !gen_b_run ? 0 : (rb_q < START ? rb_q + 1 : rb_q);
      end
   end
   assign {gen_b_breaker_open, gen_a_breaker_open, tie_open, main_b_open, main_a_open} =
      ~sh_q[14:10];
   // a bus is dead with its main and generator breaker open and the tie or the other main open
   assign dead_a = main_a_open & gen_a_breaker_open & (tie_open | main_b_open);
   assign dead_b = main_b_open & gen_b_breaker_open & (tie_open | main_a_open);
   assign gen_a_running = (ra_q == START);
   assign gen_b_running = (rb_q == START);
endmodule // bts_field_model
`default_nettype wire

// ### verification/bts_sequencer_properties.sv
// concurrent checks on the sequencer ports, bound into the sequencer module
`timescale 1ns/1ps
`default_nettype none
module bts_seq_checker
#(
   parameter [27:0] SEC_CYCLES = 28'hA
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // relays and contacts
   input wire logic src_loss_a,
   input wire logic src_loss_b,
   input wire logic dead_a,
   input wire logic dead_b,
   input wire logic main_a_open,
   input wire logic main_b_open,
   input wire logic tie_open,
   input wire logic gen_a_breaker_open,
   input wire logic gen_a_running,
   input wire logic gen_a_fault,
   input wire logic gen_a_fire,
   // commands
   input wire logic main_a_close,
   input wire logic main_b_close,
   input wire logic tie_close,
   input wire logic gen_a_breaker_close,
   input wire logic gen_a_run,
   input wire logic gen_b_run
);
   // an n second delay may run to n+1 s plus the output stage
   localparam int SEC      = int'(SEC_CYCLES);
   localparam int LOSS_LIM = 6 * SEC + 3;
   localparam int BOTH_LIM = 11 * SEC + 3;
   localparam int GEN_LIM  = 16 * SEC + 3;
   int loss_a_q;
   int both_q;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loss_a_q <= 0;
         both_q   <= 0;
      end
      else
      begin
         loss_a_q <= !src_loss_a ? 0 : (loss_a_q < LOSS_LIM ? loss_a_q + 1 : loss_a_q);
         both_q <= !(src_loss_a && src_loss_b) ? 0 : (both_q < GEN_LIM ? both_q + 1 : both_q);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   tie_both_lost_a:
      assert property (src_loss_a && src_loss_b && !tie_close |=> !tie_close)
      else $error("tie closed with both sources lost");
   tie_mains_shut_a:
      assert property (!main_a_open && !main_b_open && !tie_close |=> !tie_close)
      else $error("tie closed with both mains closed");
   tie_close_dead_a:
      assert property ($rose(tie_close) |-> $past(main_a_open && dead_a || main_b_open && dead_b))
      else $error("tie closed onto a live or unopened bus");
   main_loss_open_a:
      assert property (loss_a_q == LOSS_LIM && !src_loss_b |-> !main_a_close)
      else $error("main a still closed after sustained loss");
   mains_both_open_a:
      assert property (both_q >= BOTH_LIM |-> !main_a_close && !main_b_close)
      else $error("mains still closed after double loss");
   gen_call_both_a:
      assert property (both_q == GEN_LIM |-> gen_a_run && gen_b_run)
      else $error("generators not called after double loss");
   gen_close_ready_a:
      assert property ($rose(gen_a_breaker_close) |->
                       $past(gen_a_running && !gen_a_fault && !gen_a_fire))
      else $error("gen a breaker closed on an unready set");
   run_drop_open_a:
      assert property ($fell(gen_a_breaker_close) |-> ##[0:2] !gen_a_run)
      else $error("gen a run kept after its breaker opened");
   main_close_dead_a:
      assert property ($rose(main_a_close) |-> $past(dead_a && tie_open && gen_a_breaker_open))
      else $error("main a closed onto a live bus");
endmodule // bts_seq_checker
bind bts_sequencer bts_seq_checker #(.SEC_CYCLES(SEC_CYCLES)) bts_seq_checker_i (
   .clk, .rst, .src_loss_a, .src_loss_b, .dead_a, .dead_b, .main_a_open, .main_b_open,
   .tie_open, .gen_a_breaker_open, .gen_a_running, .gen_a_fault, .gen_a_fire, .main_a_close,
   .main_b_close, .tie_close, .gen_a_breaker_close, .gen_a_run, .gen_b_run);
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the bus transfer sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bts_defines.vh"
module tb;
   localparam int S = 10;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, lvl;
   logic [9:0]  gst;
   logic        src_loss_a, src_loss_b, dead_a, dead_b, tie_open, tie_close;
   logic        main_a_open, main_b_open, gen_a_breaker_open, gen_b_breaker_open;
   logic        main_a_close, main_b_close, gen_a_breaker_close, gen_b_breaker_close;
   logic        gen_a_running, gen_b_running, gen_a_run, gen_b_run;
   int          errors, tests_run, seed, i, n;
   bts_sequencer #(.SEC_CYCLES(28'hA)) bts_sequencer_i (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .src_loss_a, .src_loss_b, .dead_a, .dead_b, .main_a_open, .main_b_open, .tie_open,
      .gen_a_breaker_open, .gen_b_breaker_open,
      .gen_a_fire(gst[0]), .gen_a_running, .gen_a_fault(gst[1]), .gen_a_leak(gst[2]),
      .gen_a_tank_hi(gst[3]), .gen_a_tank_lo(gst[4]), .gen_a_level(lvl[15:0]),
      .gen_b_fire(gst[5]), .gen_b_running, .gen_b_fault(gst[6]), .gen_b_leak(gst[7]),
      .gen_b_tank_hi(gst[8]), .gen_b_tank_lo(gst[9]), .gen_b_level(lvl[31:16]),
      .main_a_close, .main_b_close, .tie_close, .gen_a_breaker_close, .gen_b_breaker_close,
      .gen_a_run, .gen_b_run);
   bts_field_model #(.START(12)) bts_field_model_i (
      .clk, .rst, .main_a_close, .main_b_close, .tie_close, .gen_a_breaker_close,
      .gen_b_breaker_close, .gen_a_run, .gen_b_run, .main_a_open, .main_b_open, .tie_open,
      .gen_a_breaker_open, .gen_b_breaker_open, .dead_a, .dead_b, .gen_a_running,
      .gen_b_running);
   always #2 clk = ~clk;
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      // no cycle limit here: a hung slave is caught by the watchdog
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] gen_word(input logic [9:0] g);
      return {18'h0, g[9:7], g[6], 1'b0, g[5], 2'h0, g[4:2], g[1], 1'b0, g[0]};
   endfunction
   task automatic results;
      if (errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #40000;
      errors++;
      $display("FAIL %0t watchdog expired", $time);
      results;
   end
   initial
   begin
      seed = 32'hD0AE;
      errors = 0;
      tests_run = 0;
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      src_loss_a = 1'b0;
      src_loss_b = 1'b0;
      gst = 10'h000;
      lvl = 32'h0;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      chk({main_a_close, main_b_close, tie_close, gen_a_run, gen_b_run}, 32'h18);
      gst <= 10'($random(seed)) & 10'h39C;
      lvl <= $random(seed);
      apb(1'b0, `BTS_REG_CTRL, 32'h0);
      chk(rd, 32'h13);
      apb(1'b0, `BTS_REG_GEN, 32'h0);
      chk(rd, gen_word(gst));
      apb(1'b0, `BTS_REG_TANK, 32'h0);
      chk(rd, lvl);
      // unmapped offset: error flagged, read data zero
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
      // short losses must never add up to a trip
      for (i = 0; i < 2; i++)
      begin
         n = S * (1 + ($random(seed) & 3)) + i;
         src_loss_a <= 1'b1;
         cyc(n);
         src_loss_a <= 1'b0;
         cyc(S);
      end
      chk(main_a_close, 1);
      src_loss_a <= 1'b1;
      cyc(4 * S + 5);
      chk(main_a_close, 1);
      cyc(2 * S);
      chk(main_a_close, 0);
      cyc(8 * S);
      chk(tie_close, 0);
      cyc(3 * S + 5);
      chk(tie_close, 1);
      apb(1'b1, `BTS_REG_CTRL, 32'h11);
      src_loss_a <= 1'b0;
      cyc(12 * S);
      chk(tie_close, 1);
      apb(1'b1, `BTS_REG_CTRL, 32'h13);
      cyc(S);
      chk(tie_close, 0);
      cyc(8 * S);
      chk(main_a_close, 0);
      cyc(3 * S);
      chk(main_a_close, 1);
      // double loss, with set b faulted at first
      gst <= gst | 10'h040;
      src_loss_a <= 1'b1;
      src_loss_b <= 1'b1;
      cyc(11 * S + 5);
      chk({main_a_close, main_b_close, tie_close}, 0);
      cyc(5 * S);
      chk({gen_a_run, gen_b_run}, 3);
      // the set needs its start-up time after a late run request
      cyc(S + 5);
      chk({gen_a_breaker_close, gen_b_breaker_close}, 2);
      gst <= gst & 10'h3BF;
      cyc(S);
      chk({gen_a_breaker_close, gen_b_breaker_close}, 3);
      src_loss_a <= 1'b0;
      src_loss_b <= 1'b0;
      cyc(9 * S);
      chk({gen_a_breaker_close, gen_b_breaker_close}, 3);
      cyc(2 * S + 5);
      chk({gen_a_breaker_close, gen_b_breaker_close, gen_a_run, gen_b_run}, 0);
      cyc(3 * S);
      chk({main_a_close, main_b_close}, 0);
      cyc(3 * S + 5);
      chk({main_a_close, main_b_close}, 3);
      // bus a transfer test, then manual return
      apb(1'b1, `BTS_REG_CTRL, 32'h17);
      cyc(4 * S);
      chk(main_a_close, 1);
      cyc(3 * S);
      chk({main_a_close, gen_a_run}, 1);
      cyc(7 * S);
      chk(gen_a_breaker_close, 0);
      cyc(4 * S);
      chk({gen_a_breaker_close, tie_close}, 2);
      apb(1'b1, `BTS_REG_CTRL, 32'h13);
      apb(1'b1, `BTS_REG_CMD, 32'h8);
      cyc(S);
      chk(gen_a_breaker_close, 1);
      cyc(10 * S);
      apb(1'b1, `BTS_REG_CMD, 32'h8);
      cyc(S);
      chk({gen_a_breaker_close, gen_a_run}, 0);
      cyc(6 * S);
      chk(main_a_close, 0);
      apb(1'b1, `BTS_REG_CMD, 32'h2);
      cyc(S);
      chk(main_a_close, 1);
      // bus b transfer test under the tie scheme, then manual return
      apb(1'b1, `BTS_REG_CTRL, 32'h0B);
      cyc(4 * S);
      chk(main_b_close, 1);
      cyc(3 * S);
      chk({main_b_close, tie_close}, 0);
      cyc(8 * S);
      chk(tie_close, 0);
      cyc(3 * S);
      chk(tie_close, 1);
      apb(1'b1, `BTS_REG_CTRL, 32'h03);
      apb(1'b1, `BTS_REG_CMD, 32'h1);
      cyc(S);
      chk(tie_close, 0);
      apb(1'b1, `BTS_REG_CMD, 32'h4);
      cyc(S);
      chk(main_b_close, 0);
      cyc(10 * S);
      apb(1'b1, `BTS_REG_CMD, 32'h4);
      cyc(S);
      chk(main_b_close, 1);
      results;
   end
endmodule // tb
`default_nettype wire
